// ===== hdl/adcsq_pkg.sv
// Package for the conversion sequencer: offsets, fields, reset values, types.
// Assumes a classic Wishbone bus with 32-bit data and byte addresses.
// Operation
// - Start bit begins conversion, reads busy
// - Completion clears start, sets done, loads
// - Eight-bit result by successive approximation
// - Done flag set regardless of irq enable
// - Start cleared early aborts, fill undecided bits
// - Reset restores bits, stops converter
// - RC clock delays start one cycle
// - Sleep without RC clock aborts conversion
// - Sleep with RC clock completes, may wake
// - Interrupt only when irq enable set
// - Wake resumes; vector needs global, peripheral
// - Reference selectable internal or external
// - Channel code routes inputs, 1111 reference
// - Special event trigger sets start bit
package adcsq_pkg;
   localparam logic [7:0] ADCSQ_OFF_CTRL0  = 8'h00;
   localparam logic [7:0] ADCSQ_OFF_CTRL1  = 8'h04;
   localparam logic [7:0] ADCSQ_OFF_RESULT = 8'h08;
   localparam logic [7:0] ADCSQ_OFF_STATUS = 8'h0C;
   localparam logic [7:0] ADCSQ_OFF_MASK   = 8'h10;
   localparam logic [7:0] ADCSQ_OFF_IRQCTL = 8'h14;
   localparam int ADCSQ_BIT_ENABLE = 0;
   localparam int ADCSQ_BIT_START  = 1;
   localparam int ADCSQ_POS_CHAN   = 2;
   localparam int ADCSQ_BIT_RCCLK  = 0;
   localparam int ADCSQ_BIT_EXTREF = 1;
   localparam int ADCSQ_BIT_DONE   = 0;
   localparam int ADCSQ_BIT_ABORT  = 1;
   localparam int ADCSQ_BIT_GIE    = 0;
   localparam int ADCSQ_BIT_PERIPHERAL_IRQ_ENABLE   = 1;
   localparam logic [7:0] ADCSQ_RST_CTRL0 = 8'h00;
   localparam logic [7:0] ADCSQ_RST_CTRL1 = 8'h00;
   localparam logic [3:0] ADCSQ_CHAN_RSVD  = 4'hE;
   localparam logic [3:0] ADCSQ_CHAN_FVREF = 4'hF;
   localparam int ADCSQ_RES_BITS = 8;
   localparam int ADCSQ_RC_DELAY_CYC = 1;
   localparam int ADCSQ_NUM_EVT = 2;

   typedef enum logic [1:0] {ADCSQ_IDLE, ADCSQ_DELAY, ADCSQ_CONV} adcsq_state_e;

   typedef struct packed {
      logic [3:0] chan;
      logic       start;
      logic       enable;
   } adcsq_ctrl_s;

   typedef struct packed {
      logic [7:0]  adr;
      logic        we;
      logic [3:0]  sel;
      logic [31:0] dat;
      logic        req;
   } adcsq_wbreq_s;
endpackage

// ===== hdl/adcsq_sar.sv
// Successive-approximation step engine, one bit decided per clock.
// Assumes comparator output is synchronous and answers the trial code.
`timescale 1ns/1ps
module adcsq_sar
   import adcsq_pkg::*;
#(
   parameter int W = ADCSQ_RES_BITS
)(
   input  wire logic         mclk,
   input  wire logic         srst,
   input  wire logic         go,
   input  wire logic         stop,
   input  wire logic         cmp_hi,
   output logic [W-1:0]      trial,
   output logic [W-1:0]      value,
   output logic              busy,
   output logic              done
);
   typedef struct packed {
      logic [W-1:0] code;
      logic [W-1:0] bitp;
      logic [W-1:0] res;
      logic         busy;
      logic         done;
   } adcsq_sar_s;
   adcsq_sar_s st_reg, st_next;
   logic [W-1:0] filled;
   logic         lastb;

   always_comb
   begin
      st_next = st_reg;
      st_next.done = 1'b0;
      lastb = |(st_reg.code & (st_reg.bitp << 1));
      filled = st_reg.code;
      for (int i = 0; i < W; i++)
      begin
         if ((st_reg.bitp >> i) != '0)
         begin
            filled[i] = lastb;
         end
      end
      if (stop || !st_reg.busy)
      begin
         st_next.busy = 1'b0;
         if (stop && st_reg.busy)
         begin
            st_next.res = (st_reg.bitp == {1'b1, {(W-1){1'b0}}}) ? st_reg.code : filled;
         end
         if (go && !stop)
         begin
            st_next.busy = 1'b1;
            st_next.bitp = {1'b1, {(W-1){1'b0}}};
            st_next.code = '0;
         end
      end
      else
      begin
         st_next.code = st_reg.code | (cmp_hi ? st_reg.bitp : '0);
         st_next.bitp = st_reg.bitp >> 1;
         if (st_reg.bitp[0])
         begin
            st_next.busy = 1'b0;
            st_next.done = 1'b1;
            st_next.res = st_reg.code | (cmp_hi ? st_reg.bitp : '0);
         end
      end
      if (srst)
      begin
         st_next = '0;
      end
   end

   always_ff @(posedge mclk)
   begin
      st_reg <= st_next;
   end

   assign trial = st_reg.code | st_reg.bitp;
   assign value = st_reg.res;
   assign busy = st_reg.busy;
   assign done = st_reg.done;
endmodule

// ===== hdl/adcsq_top.sv
// Conversion sequencer top: control registers, start/abort/sleep logic, irq.
// Assumes an external comparator and analog mux driven by the outputs here.
`timescale 1ns/1ps
module adcsq_top
   import adcsq_pkg::*;
#(
   parameter int W = ADCSQ_RES_BITS
)(
   input  wire logic         mclk,
   input  wire logic         srst,
   input  wire logic         wb_cyc_i,
   input  wire logic         wb_stb_i,
   input  wire logic         wb_we_i,
   input  wire logic [7:0]   wb_adr_i,
   input  wire logic [3:0]   wb_sel_i,
   input  wire logic [31:0]  wb_dat_i,
   output logic [31:0]       wb_dat_o,
   output logic              wb_ack_o,
   input  wire logic         cmp_hi,
   input  wire logic         special_trig,
   input  wire logic         sleep_exec,
   output logic [W-1:0]      dac_code,
   output logic [3:0]        mux_chan,
   output logic              mux_fvref,
   output logic              ref_external,
   output logic              conv_power,
   output logic              wake,
   output logic              irq_vector,
   output logic              irq
);
   typedef struct packed {
      adcsq_ctrl_s  ctrl;
      logic         rcclk;
      logic         extref;
      logic         global_irq_enable;
      logic         peripheral_irq_enable;
      logic [ADCSQ_NUM_EVT-1:0] status;
      logic [ADCSQ_NUM_EVT-1:0] mask;
      logic [W-1:0] result;
      adcsq_state_e state;
      logic         asleep;
      logic         powered;
      logic         wake;
      logic [31:0]  rdata;
   } adcsq_top_s;
   adcsq_top_s st_reg, st_next;
   adcsq_wbreq_s req;
   logic [W-1:0] sar_value;
   logic         sar_busy;
   logic         sar_done;
   logic         sar_go;
   logic         sar_stop;
   logic         wr;
   logic         start_req;
   logic [ADCSQ_NUM_EVT-1:0] evt;

   adcsq_wb u_wb (
      .mclk     (mclk),
      .srst     (srst),
      .wb_cyc_i (wb_cyc_i),
      .wb_stb_i (wb_stb_i),
      .wb_we_i  (wb_we_i),
      .wb_adr_i (wb_adr_i),
      .wb_sel_i (wb_sel_i),
      .wb_dat_i (wb_dat_i),
      .wb_ack_o (wb_ack_o),
      .req      (req)
   );

   adcsq_sar #(.W(W)) u_sar (
      .mclk   (mclk),
      .srst   (srst),
      .go     (sar_go),
      .stop   (sar_stop),
      .cmp_hi (cmp_hi),
      .trial  (dac_code),
      .value  (sar_value),
      .busy   (sar_busy),
      .done   (sar_done)
   );

   always_comb
   begin
      st_next = st_reg;
      st_next.wake = 1'b0;
      wr = req.req && req.we && req.sel[0];
      start_req = 1'b0;
      sar_go = 1'b0;
      sar_stop = 1'b0;
      evt = '0;
      // Control register write; start only when enable already set
      if (wr && req.adr == ADCSQ_OFF_CTRL0)
      begin
         st_next.ctrl.enable = req.dat[ADCSQ_BIT_ENABLE];
         st_next.ctrl.chan = req.dat[ADCSQ_POS_CHAN +: 4];
         if (!req.dat[ADCSQ_BIT_START])
         begin
            st_next.ctrl.start = 1'b0;
         end
         else if (st_reg.ctrl.enable && req.dat[ADCSQ_BIT_ENABLE])
         begin
            start_req = 1'b1;
         end
      end
      if (special_trig && st_reg.ctrl.enable)
      begin
         start_req = 1'b1;
      end
      if (start_req && !st_reg.ctrl.start)
      begin
         st_next.ctrl.start = 1'b1;
         st_next.powered = 1'b1;
         st_next.state = st_reg.rcclk ? ADCSQ_DELAY : ADCSQ_CONV;
         sar_go = !st_reg.rcclk;
      end
      if (wr && req.adr == ADCSQ_OFF_CTRL1)
      begin
         st_next.rcclk = req.dat[ADCSQ_BIT_RCCLK];
         st_next.extref = req.dat[ADCSQ_BIT_EXTREF];
      end
      if (wr && req.adr == ADCSQ_OFF_MASK)
      begin
         st_next.mask = req.dat[ADCSQ_NUM_EVT-1:0];
      end
      if (wr && req.adr == ADCSQ_OFF_IRQCTL)
      begin
         st_next.global_irq_enable = req.dat[ADCSQ_BIT_GIE];
         st_next.peripheral_irq_enable = req.dat[ADCSQ_BIT_PERIPHERAL_IRQ_ENABLE];
      end
      if (sleep_exec)
      begin
         st_next.asleep = 1'b1;
      end
      case (st_reg.state)
         ADCSQ_IDLE:
         begin
         end
         ADCSQ_DELAY:
         begin
            if (!st_next.ctrl.start || (sleep_exec && !st_reg.rcclk))
            begin
               st_next.state = ADCSQ_IDLE;
            end
            else
            begin
               sar_go = 1'b1;
               st_next.state = ADCSQ_CONV;
            end
         end
         ADCSQ_CONV:
         begin
            if (!st_next.ctrl.start || (sleep_exec && !st_reg.rcclk))
            begin
               sar_stop = 1'b1;
               st_next.ctrl.start = 1'b0;
               st_next.state = ADCSQ_IDLE;
               evt[ADCSQ_BIT_ABORT] = 1'b1;
               if (sleep_exec)
               begin
                  st_next.powered = 1'b0;
               end
            end
            else if (sar_done)
            begin
               st_next.ctrl.start = 1'b0;
               st_next.result = sar_value;
               evt[ADCSQ_BIT_DONE] = 1'b1;
               st_next.state = ADCSQ_IDLE;
               if (st_reg.asleep)
               begin
                  if (st_reg.mask[ADCSQ_BIT_DONE])
                  begin
                     st_next.wake = 1'b1;
                     st_next.asleep = 1'b0;
                  end
                  else
                  begin
                     st_next.powered = 1'b0;
                  end
               end
            end
         end
         default:
         begin
            st_next.state = ADCSQ_IDLE;
         end
      endcase
      // Abort result lands one cycle later from the SAR
      if (!sar_busy && st_reg.state == ADCSQ_IDLE && st_reg.status[ADCSQ_BIT_ABORT])
      begin
         st_next.result = sar_value;
      end
      if (wr && req.adr == ADCSQ_OFF_STATUS)
      begin
         st_next.status = st_reg.status & ~req.dat[ADCSQ_NUM_EVT-1:0];
      end
      st_next.status = st_next.status | evt;
      if (!st_next.ctrl.enable)
      begin
         st_next.powered = 1'b0;
      end
      case (req.adr)
         ADCSQ_OFF_CTRL0:  st_next.rdata = {26'h0, st_next.ctrl};
         ADCSQ_OFF_CTRL1:  st_next.rdata = {30'h0, st_reg.extref, st_reg.rcclk};
         ADCSQ_OFF_RESULT: st_next.rdata = {{(32-W){1'b0}}, st_reg.result};
         ADCSQ_OFF_STATUS: st_next.rdata = {30'h0, st_reg.status};
         ADCSQ_OFF_MASK:   st_next.rdata = {30'h0, st_reg.mask};
         ADCSQ_OFF_IRQCTL: st_next.rdata = {30'h0, st_reg.peripheral_irq_enable, st_reg.global_irq_enable};
         default:          st_next.rdata = 32'h0000_0000;
      endcase
      if (srst)
      begin
         st_next = '0;
         st_next.ctrl = adcsq_ctrl_s'(ADCSQ_RST_CTRL0[5:0]);
      end
   end

   always_ff @(posedge mclk)
   begin
      st_reg <= st_next;
   end

   assign wb_dat_o = st_reg.rdata;
   assign mux_chan = st_reg.ctrl.chan;
   assign mux_fvref = (st_reg.ctrl.chan == ADCSQ_CHAN_FVREF);
   assign ref_external = st_reg.extref;
   assign conv_power = st_reg.powered && st_reg.ctrl.enable;
   assign wake = st_reg.wake;
   assign irq = |(st_reg.status & st_reg.mask);
   assign irq_vector = irq && st_reg.global_irq_enable && st_reg.peripheral_irq_enable;
endmodule

// ===== hdl/adcsq_wb.sv
// Classic Wishbone slave front end: one registered ack per request.
// Assumes a single master holding the request until ack is seen.
`timescale 1ns/1ps
module adcsq_wb
   import adcsq_pkg::*;
(
   input  wire logic         mclk,
   input  wire logic         srst,
   input  wire logic         wb_cyc_i,
   input  wire logic         wb_stb_i,
   input  wire logic         wb_we_i,
   input  wire logic [7:0]   wb_adr_i,
   input  wire logic [3:0]   wb_sel_i,
   input  wire logic [31:0]  wb_dat_i,
   output logic              wb_ack_o,
   output adcsq_wbreq_s      req
);
   logic ack_reg, ack_next;

   always_comb
   begin
      ack_next = wb_cyc_i && wb_stb_i && !ack_reg;
      if (srst)
      begin
         ack_next = 1'b0;
      end
   end

   always_ff @(posedge mclk)
   begin
      ack_reg <= ack_next;
   end

   assign wb_ack_o = ack_reg;
   // Request acts at the acked edge only
   assign req = '{adr: wb_adr_i, we: wb_we_i, sel: wb_sel_i, dat: wb_dat_i, req: ack_reg};
endmodule

// ===== verif/adc_conversion_sequencer_tb.sv
// Self-checking bench for the conversion sequencer.
// Assumes the comparator model and checker beside it.
`timescale 1ns/1ps
module adc_conversion_sequencer_tb;
   import adcsq_pkg::*;
   logic        mclk, srst, wb_cyc_i, wb_stb_i, wb_we_i, special_trig, sleep_exec;
   logic        cmp_hi, wb_ack_o, mux_fvref, ref_external, conv_power, wake, irq_vector, irq;
   logic [7:0]  wb_adr_i, level, dac_code;
   logic [3:0]  wb_sel_i, mux_chan, ch;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   int          n_fail, compares, n, g, t[2];
   adcsq_top #(.W(8)) i_dut (.mclk, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .cmp_hi, .special_trig, .sleep_exec,
      .dac_code, .mux_chan, .mux_fvref, .ref_external, .conv_power, .wake, .irq_vector, .irq);
   adcsq_ain_model i_ain (.level, .dac_code, .cmp_hi);
   always #5 mclk = ~mclk;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
      @(posedge mclk);
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i  <= w;
      wb_sel_i <= 4'hF;
      wb_adr_i <= a;
      wb_dat_i <= {24'h00_0000, d};
      do
      begin
         @(posedge mclk);
      end
      while (wb_ack_o !== 1'h1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
   endtask
   task automatic await(ref logic s);
      n = 0;
      while (s !== 1'h1 && n < 40)
      begin
         @(posedge mclk);
         n++;
      end
   endtask
   function automatic logic ok(input logic [7:0] v, input logic [7:0] r);
      logic [7:0] f;
      ok = 1'h0;
      for (int k = 1; k <= 8; k++)
      begin
         f = v;
         for (int b = 7 - k; b >= 0; b--)
            f[b] = f[b + 1];
         if (f === r)
            ok = 1'h1;
      end
   endfunction
   task automatic start();
      wb(ADCSQ_OFF_CTRL0, 1'h1, {2'h0, ch, 2'h3});
   endtask
   task automatic conv(input logic rc);
      wb(ADCSQ_OFF_CTRL0, 1'h1, {2'h0, ch, 2'h1});
      start();
      @(posedge mclk);
      chk(mux_chan, ch);
      chk(mux_fvref, ch == 4'hF);
      chk(conv_power, 1'h1);
      await(irq);
      chk(irq_vector, g == 3);
      t[rc] = n;
      wb(ADCSQ_OFF_CTRL0, 1'h0, 8'h00);
      chk(rd, {ch, 2'h1});
      wb(ADCSQ_OFF_RESULT, 1'h0, 8'h00);
      chk(rd, level);
      wb(ADCSQ_OFF_STATUS, 1'h0, 8'h00);
      chk(rd, 32'h0000_0001);
      wb(ADCSQ_OFF_STATUS, 1'h1, 8'h01);
      wb(ADCSQ_OFF_STATUS, 1'h0, 8'h00);
      chk(rd, 32'h0000_0000);
   endtask
   task automatic pulse(input logic slp);
      if (slp)
         sleep_exec <= 1'h1;
      else
         special_trig <= 1'h1;
      @(posedge mclk);
      sleep_exec <= 1'h0;
      special_trig <= 1'h0;
   endtask
   initial
   begin
      {mclk, wb_cyc_i, wb_stb_i, wb_we_i, special_trig, sleep_exec} = '0;
      {wb_adr_i, wb_dat_i, level, ch, n_fail, compares} = '0;
      srst = 1'h1;
      wb_sel_i = 4'hF;
      void'($urandom(32'h30b2_8250));
      repeat (4) @(posedge mclk);
      srst <= 1'h0;
      wb(ADCSQ_OFF_CTRL0, 1'h0, 8'h00);
      chk(rd, ADCSQ_RST_CTRL0);
      wb(ADCSQ_OFF_CTRL0, 1'h1, 8'h02);
      wb(ADCSQ_OFF_CTRL0, 1'h0, 8'h00);
      chk(rd, 32'h0000_0000);
      wb(8'h3C, 1'h0, 8'h00);
      chk(rd, 32'h0000_0000);
      wb(ADCSQ_OFF_MASK, 1'h1, 8'h01);
      for (int i = 0; i < 12; i++)
      begin
         level <= 8'($urandom);
         ch = 4'($urandom_range(15));
         g = $urandom_range(3);
         wb(ADCSQ_OFF_IRQCTL, 1'h1, 8'(g));
         wb(ADCSQ_OFF_CTRL1, 1'h1, {6'h00, i[1], i[0]});
         conv(i[0]);
         chk(ref_external, i[1]);
      end
      chk(t[1], t[0] + 1);
      wb(ADCSQ_OFF_CTRL1, 1'h1, 8'h00);
      start();
      wb(ADCSQ_OFF_CTRL0, 1'h0, 8'h00);
      chk(rd[1], 1'h1);
      wb(ADCSQ_OFF_CTRL0, 1'h1, {2'h0, ch, 2'h1});
      repeat (4) @(posedge mclk);
      wb(ADCSQ_OFF_RESULT, 1'h0, 8'h00);
      chk(ok(level, rd[7:0]), 1'h1);
      wb(ADCSQ_OFF_STATUS, 1'h0, 8'h00);
      chk(rd[1], 1'h1);
      wb(ADCSQ_OFF_STATUS, 1'h1, 8'h03);
      pulse(1'h0);
      await(irq);
      chk(n < 40, 1'h1);
      wb(ADCSQ_OFF_RESULT, 1'h0, 8'h00);
      chk(rd, level);
      wb(ADCSQ_OFF_STATUS, 1'h1, 8'h01);
      wb(ADCSQ_OFF_CTRL1, 1'h1, 8'h01);
      start();
      pulse(1'h1);
      await(wake);
      chk(n < 40, 1'h1);
      wb(ADCSQ_OFF_RESULT, 1'h0, 8'h00);
      chk(rd, level);
      wb(ADCSQ_OFF_STATUS, 1'h1, 8'h01);
      wb(ADCSQ_OFF_MASK, 1'h1, 8'h00);
      start();
      pulse(1'h1);
      repeat (14) @(posedge mclk);
      chk(conv_power, 1'h0);
      chk(irq, 1'h0);
      wb(ADCSQ_OFF_CTRL0, 1'h0, 8'h00);
      chk(rd, {ch, 2'h1});
      wb(ADCSQ_OFF_STATUS, 1'h0, 8'h00);
      chk(rd, 32'h0000_0001);
      wb(ADCSQ_OFF_STATUS, 1'h1, 8'h01);
      wb(ADCSQ_OFF_MASK, 1'h1, 8'h01);
      wb(ADCSQ_OFF_CTRL1, 1'h1, 8'h00);
      start();
      pulse(1'h1);
      repeat (2) @(posedge mclk);
      chk(conv_power, 1'h0);
      wb(ADCSQ_OFF_CTRL0, 1'h0, 8'h00);
      chk(rd[0], 1'h1);
      srst <= 1'h1;
      repeat (4) @(posedge mclk);
      srst <= 1'h0;
      wb(ADCSQ_OFF_CTRL0, 1'h0, 8'h00);
      chk(rd, 32'h0000_0000);
      give_verdict();
   end
   initial
   begin
      #200000;
      n_fail++;
      give_verdict();
   end
endmodule
bind adcsq_top adcsq_asserts #(.W(W)) i_chk (.mclk, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
   .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .cmp_hi, .special_trig, .sleep_exec,
   .dac_code, .mux_chan, .mux_fvref, .ref_external, .conv_power, .wake, .irq_vector, .irq);

// ===== verif/adcsq_ain_model.sv
// Analog source and comparator; one level serves every channel.
// Assumes the bench sets the level.
`timescale 1ns/1ps
module adcsq_ain_model
(
   input  wire logic [7:0] level,
   input  wire logic [7:0] dac_code,
   output logic            cmp_hi
);
   assign cmp_hi = (level >= dac_code);
endmodule

// ===== verif/adcsq_asserts.sv
// Checker on the sequencer top ports.
// Assumes a bind from the bench top file.
`timescale 1ns/1ps
module adcsq_asserts
   import adcsq_pkg::*;
#(
   parameter int W = ADCSQ_RES_BITS
)(
   input wire logic         mclk,
   input wire logic         srst,
   input wire logic         wb_cyc_i,
   input wire logic         wb_stb_i,
   input wire logic         wb_we_i,
   input wire logic [7:0]   wb_adr_i,
   input wire logic [3:0]   wb_sel_i,
   input wire logic [31:0]  wb_dat_i,
   input wire logic [31:0]  wb_dat_o,
   input wire logic         wb_ack_o,
   input wire logic         cmp_hi,
   input wire logic         special_trig,
   input wire logic         sleep_exec,
   input wire logic [W-1:0] dac_code,
   input wire logic [3:0]   mux_chan,
   input wire logic         mux_fvref,
   input wire logic         ref_external,
   input wire logic         conv_power,
   input wire logic         wake,
   input wire logic         irq_vector,
   input wire logic         irq
);
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   a_fvref_code: assert property (mux_fvref == (mux_chan == 4'hF))
      else $error("fvref select mismatch");
   a_vector_irq: assert property (irq_vector |-> irq)
      else $error("vector without irq");
   a_reset_quiet: assert property ($past(srst) |-> !conv_power && !irq && !wake)
      else $error("outputs active after reset");
   a_wake_pulse: assert property (wake |=> !wake)
      else $error("wake longer than one cycle");
   a_wake_irq: assert property (wake |-> ##[0:2] irq)
      else $error("wake without irq");
   a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held");
   a_read_upper: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h00_0000)
      else $error("upper read bits set");
endmodule
